//--- bmt_buzzer_melody.sv
// Purpose: two-note buzzer and melody tone generator with supply-hold timer
// Assumes: sys_clk 10 MHz, slow_32k_clock asynchronous to it
// Notes:   all outputs are flops; reads answer one cycle after the strobe
`timescale 1ns/1ps
// What this block does
// - tone is clock over base over divisor+1
// - twelve-bit divisor, A and B each split low/high registers
// - base select: clear 32, set 64
// - tone lasts unit times duration count
// - silent pause lasts unit times pause count
// - unit field gives 1/2/4/8 ms
// - unit ticks come from slow clock
// - starting any note starts supply-hold timer
// - hold expiry sets flag, software clears it
// - enable bit switches whole controller
// - invert bit flips output pin polarity
// - note end sets flag when enabled
// - start bit plays note, self clears
// - both starts together: A then B
// - playing bits read at start positions
// - play once or alternate as ping-pong
module bmt_buzzer_melody #(
  parameter int EDGES_PER_UNIT = bmt_pkg::SLOW_EDGES_PER_UNIT
) (
  input  wire logic                      sys_clk,
  input  wire logic                      rst_b,
  input  wire bmt_pkg::bmt_bus_req_type  bus_req,
  output logic [7:0]                     rd_data,
  input  wire logic                      slow_32k_clock,
  output logic                           buzzer_output_pin,
  output logic                           supply_hold_active,
  output logic                           irq
);
  import bmt_pkg::*;

  // unit counter is 9 bits wide: EDGES_PER_UNIT * 8 must fit
  if (EDGES_PER_UNIT < 1 || EDGES_PER_UNIT > 63) begin : g_chk
    $error("EDGES_PER_UNIT out of range");
  end

  // last prescale count for the selected base, half a base period
  function automatic logic [4:0] half_last(input logic sel);
    half_last = sel ? 5'(BASE_DIV_HI / 2 - 1) : 5'(BASE_DIV_LO / 2 - 1);
  endfunction

  // sticky flag: hardware set wins over a software clear
  function automatic logic flag_upd(input logic cur, input logic set,
                                    input logic clr);
    flag_upd = set | (cur & ~clr);
  endfunction

  // registers
  logic [11:0]   div_a_reg, div_b_reg;
  logic [7:0]    dur_a_reg, pau_a_reg, dur_b_reg, pau_b_reg, hold_len_reg;
  logic          en_reg, inv_reg, ie_a_reg, ie_b_reg;
  logic          flag_a_reg, flag_b_reg, go_a_reg, go_b_reg;
  logic [1:0]    tu_reg;
  logic          base_reg, hold_ie_reg, hold_flag_reg;
  logic [2:0]    irq_stat_reg, irq_mask_reg;
  logic          slow_s1_reg, slow_s2_reg, slow_prev_reg;
  logic [8:0]    unit_cnt_reg;
  bmt_state_type state_reg, state_next;
  logic          cur_b_reg, cur_b_next;
  logic [7:0]    time_reg, time_next;
  logic [4:0]    pre_reg;
  logic [12:0]   tone_reg;
  logic [7:0]    hold_cnt_reg;
  logic          hold_run_reg;
  logic [7:0]    rd_data_reg;
  logic          buzzer_reg, irq_reg;

  // address decode
  wire wr_cfg   = bus_req.wr && bus_req.addr == ADDR_CFG;
  wire wr_tu    = bus_req.wr && bus_req.addr == ADDR_TU;
  wire rd_stat  = bus_req.rd && bus_req.addr == ADDR_IRQ_STAT;
  wire [7:0] wd = bus_req.wdata;

  // effective enable after this cycle's write
  wire en_new   = wr_cfg ? wd[CFG_EN] : en_reg;
  wire go_a_set = wr_cfg & wd[CFG_EN] & wd[CFG_GOA];
  wire go_b_set = wr_cfg & wd[CFG_EN] & wd[CFG_GOB];
  wire note_start = go_a_set | go_b_set;

  // slow clock edge and time unit tick; >= so a shorter unit picked mid-count still ticks
  wire       slow_edge  = slow_s2_reg & ~slow_prev_reg;
  wire [8:0] unit_limit = 9'(EDGES_PER_UNIT) << tu_reg;
  wire       unit_tick  = slow_edge && unit_cnt_reg >= unit_limit - 9'h001;

  // note finishes when its pause has run out
  wire note_done = state_reg == ST_PAUSE && time_reg == 8'h00;
  wire done_a    = note_done & ~cur_b_reg;
  wire done_b    = note_done & cur_b_reg;

  // supply-hold timer expiry
  wire hold_expire = hold_run_reg & unit_tick & (hold_cnt_reg <= 8'h01);

  // go bits: a fresh write is kept even if the note ends now
  wire go_a_next = en_new & (go_a_set | (go_a_reg & ~done_a));
  wire go_b_next = en_new & (go_b_set | (go_b_reg & ~done_b));

  // end flags, cleared by writing zero
  wire fa_next = flag_upd(flag_a_reg, done_a & ie_a_reg,
                          wr_cfg & ~wd[CFG_FA]);
  wire fb_next = flag_upd(flag_b_reg, done_b & ie_b_reg,
                          wr_cfg & ~wd[CFG_FB]);
  wire fh_next = flag_upd(hold_flag_reg, hold_expire,
                          wr_tu & ~wd[TU_FLAG]);

  // interrupt events; a read of the status register clears them
  wire [2:0] irq_ev = {hold_expire & hold_ie_reg, done_b & ie_b_reg,
                       done_a & ie_a_reg};
  wire [2:0] stat_next = irq_ev | (irq_stat_reg & ~{3{rd_stat}});

  // playing status for read-back
  wire play_a = state_reg != ST_IDLE && !cur_b_reg;
  wire play_b = state_reg != ST_IDLE && cur_b_reg;

  // tone generation: half-base prescaler then divisor counter
  wire [11:0] div_cur  = cur_b_reg ? div_b_reg : div_a_reg;
  wire        pre_tick = pre_reg == half_last(base_reg);
  wire [12:0] tone_last = {div_cur, 1'b1};
  wire        phase    = tone_reg <= {1'b0, div_cur};
  wire        buz_next = ((state_reg == ST_TONE) & phase) ^ inv_reg;

  // sequencer next state
  always_comb begin
    state_next = state_reg;
    cur_b_next = cur_b_reg;
    time_next  = time_reg;
    case (state_reg)
      ST_IDLE: begin
        // A wins when both are pending
        if (go_a_reg) begin
          state_next = ST_TONE;
          cur_b_next = 1'b0;
          time_next  = dur_a_reg;
        end else if (go_b_reg) begin
          state_next = ST_TONE;
          cur_b_next = 1'b1;
          time_next  = dur_b_reg;
        end
      end
      ST_TONE: begin
        if (time_reg == 8'h00) begin
          state_next = ST_PAUSE;
          time_next  = cur_b_reg ? pau_b_reg : pau_a_reg;
        end else if (unit_tick) begin
          time_next = time_reg - 8'h01;
        end
      end
      ST_PAUSE: begin
        // hand over to the other pending note: ping-pong
        if (time_reg == 8'h00) begin
          if (done_a && go_b_reg) begin
            state_next = ST_TONE;
            cur_b_next = 1'b1;
            time_next  = dur_b_reg;
          end else if (done_b && go_a_reg) begin
            state_next = ST_TONE;
            cur_b_next = 1'b0;
            time_next  = dur_a_reg;
          end else begin
            state_next = ST_IDLE;
          end
        end else if (unit_tick) begin
          time_next = time_reg - 8'h01;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
    if (!en_new) begin
      state_next = ST_IDLE;
      time_next  = 8'h00;
    end
  end

  // read mux; unmapped addresses read zero
  logic [7:0] rd_mux;
  always_comb begin
    case (bus_req.addr)
      ADDR_A_DIV_LO: rd_mux = div_a_reg[7:0];
      ADDR_A_DIV_HI: rd_mux = {4'h0, div_a_reg[11:8]};
      ADDR_A_DUR:    rd_mux = dur_a_reg;
      ADDR_A_PAU:    rd_mux = pau_a_reg;
      ADDR_B_DIV_LO: rd_mux = div_b_reg[7:0];
      ADDR_B_DIV_HI: rd_mux = {4'h0, div_b_reg[11:8]};
      ADDR_B_DUR:    rd_mux = dur_b_reg;
      ADDR_B_PAU:    rd_mux = pau_b_reg;
      ADDR_CFG:      rd_mux = {en_reg, inv_reg, ie_b_reg, ie_a_reg,
                               flag_b_reg, flag_a_reg, play_b, play_a};
      ADDR_HOLD:     rd_mux = hold_len_reg;
      ADDR_TU:       rd_mux = {tu_reg, 1'b0, base_reg, 2'b00,
                               hold_ie_reg, hold_flag_reg};
      ADDR_IRQ_STAT: rd_mux = {5'h00, irq_stat_reg};
      ADDR_IRQ_MASK: rd_mux = {5'h00, irq_mask_reg};
      default:       rd_mux = 8'h00;
    endcase
  end

  // plain storage registers written by software
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      div_a_reg    <= {4'h0, REG_RESET};
      div_b_reg    <= {4'h0, REG_RESET};
      dur_a_reg    <= REG_RESET;
      pau_a_reg    <= REG_RESET;
      dur_b_reg    <= REG_RESET;
      pau_b_reg    <= REG_RESET;
      hold_len_reg <= REG_RESET;
      irq_mask_reg <= REG_RESET[2:0];
    end else if (bus_req.wr) begin
      case (bus_req.addr)
        ADDR_A_DIV_LO: div_a_reg[7:0]  <= wd;
        ADDR_A_DIV_HI: div_a_reg[11:8] <= wd[3:0];
        ADDR_A_DUR:    dur_a_reg       <= wd;
        ADDR_A_PAU:    pau_a_reg       <= wd;
        ADDR_B_DIV_LO: div_b_reg[7:0]  <= wd;
        ADDR_B_DIV_HI: div_b_reg[11:8] <= wd[3:0];
        ADDR_B_DUR:    dur_b_reg       <= wd;
        ADDR_B_PAU:    pau_b_reg       <= wd;
        ADDR_HOLD:     hold_len_reg    <= wd;
        ADDR_IRQ_MASK: irq_mask_reg    <= wd[2:0];
        default:       irq_mask_reg    <= irq_mask_reg;
      endcase
    end
  end

  // control bits and flags
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      {en_reg, inv_reg, ie_b_reg, ie_a_reg} <= REG_RESET[7:4];
      {flag_b_reg, flag_a_reg, go_b_reg, go_a_reg} <= REG_RESET[3:0];
      {tu_reg, base_reg, hold_ie_reg, hold_flag_reg} <= REG_RESET[4:0];
      irq_stat_reg <= REG_RESET[2:0];
    end else begin
      en_reg        <= en_new;
      go_a_reg      <= go_a_next;
      go_b_reg      <= go_b_next;
      flag_a_reg    <= fa_next;
      flag_b_reg    <= fb_next;
      hold_flag_reg <= fh_next;
      irq_stat_reg  <= stat_next;
      if (wr_cfg) begin
        {inv_reg, ie_b_reg, ie_a_reg} <= wd[CFG_INV:CFG_IEA];
      end
      if (wr_tu) begin
        tu_reg      <= wd[TU_MSB:TU_LSB];
        base_reg    <= wd[TU_BASE];
        hold_ie_reg <= wd[TU_IE];
      end
    end
  end

  // slow clock synchroniser and unit counter
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      slow_s1_reg   <= 1'b0;
      slow_s2_reg   <= 1'b0;
      slow_prev_reg <= 1'b0;
      unit_cnt_reg  <= 9'h000;
    end else begin
      slow_s1_reg   <= slow_32k_clock;
      slow_s2_reg   <= slow_s1_reg;
      slow_prev_reg <= slow_s2_reg;
      if (!en_reg || unit_tick) begin
        unit_cnt_reg <= 9'h000;
      end else if (slow_edge) begin
        unit_cnt_reg <= unit_cnt_reg + 9'h001;
      end
    end
  end

  // sequencer, tone counters and supply-hold timer
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg    <= ST_IDLE;
      cur_b_reg    <= 1'b0;
      time_reg     <= 8'h00;
      pre_reg      <= 5'h00;
      tone_reg     <= 13'h0000;
      hold_cnt_reg <= 8'h00;
      hold_run_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cur_b_reg <= cur_b_next;
      time_reg  <= time_next;
      // counters restart with each tone so every note opens in phase
      if (state_next != ST_TONE || state_reg != ST_TONE || pre_tick) begin
        pre_reg <= 5'h00;
      end else begin
        pre_reg <= pre_reg + 5'h01;
      end
      if (state_next != ST_TONE || state_reg != ST_TONE) begin
        tone_reg <= 13'h0000;
      end else if (pre_tick) begin
        tone_reg <= (tone_reg == tone_last) ? 13'h0000 : tone_reg + 13'h0001;
      end
      if (!en_new) begin
        hold_run_reg <= 1'b0;
      end else if (note_start) begin
        hold_run_reg <= 1'b1;
        hold_cnt_reg <= hold_len_reg;
      end else if (hold_run_reg && unit_tick) begin
        hold_run_reg <= ~hold_expire;
        hold_cnt_reg <= hold_cnt_reg - 8'h01;
      end
    end
  end

  // output flops
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_data_reg <= 8'h00;
      buzzer_reg  <= 1'b0;
      irq_reg     <= 1'b0;
    end else begin
      rd_data_reg <= bus_req.rd ? rd_mux : 8'h00;
      buzzer_reg  <= buz_next;
      irq_reg     <= |(stat_next & irq_mask_reg);
    end
  end

  assign rd_data            = rd_data_reg;
  assign buzzer_output_pin  = buzzer_reg;
  assign supply_hold_active = hold_run_reg;
  assign irq                = irq_reg;

  // checks
  quiet_out_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (state_reg != ST_TONE) |=> (buzzer_reg == $past(inv_reg)))
    else $error("output not inactive outside tone");
  disable_stop_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (wr_cfg && !wd[CFG_EN]) |=> (state_reg == ST_IDLE && !go_a_reg && !go_b_reg))
    else $error("disable did not stop the note");
  a_first_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (state_reg == ST_IDLE && go_a_reg && go_b_reg && en_new)
      |=> (state_reg == ST_TONE && !cur_b_reg))
    else $error("note B played before note A");
  start_play_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (state_reg == ST_IDLE && !go_a_reg && !go_b_reg && go_a_set)
      |=> ##1 (state_reg == ST_TONE && !cur_b_reg))
    else $error("start did not play note A");
  hold_flag_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (hold_expire && !note_start) |=> hold_flag_reg && !hold_run_reg)
    else $error("hold expiry lost");
  end_flag_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (done_b && ie_b_reg) |=> flag_b_reg)
    else $error("note end flag not set");
  hold_start_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    note_start |=> (hold_run_reg && hold_cnt_reg == $past(hold_len_reg)))
    else $error("hold timer not started");
  pause_len_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (state_reg == ST_TONE && time_reg == 8'h00 && en_new)
      |=> (state_reg == ST_PAUSE &&
           time_reg == (cur_b_reg ? $past(pau_b_reg) : $past(pau_a_reg))))
    else $error("pause not loaded");
  base_len_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (state_reg == ST_TONE && state_next == ST_TONE && !pre_tick)
      |=> (pre_reg == $past(pre_reg) + 5'h01))
    else $error("prescaler stalled");
endmodule // bmt_buzzer_melody

//--- bmt_buzzer_partner.sv
// Purpose: buzzer element and power switch seen from the pins
// Assumes: sampled on sys_clk, so edges are measured in whole cycles
// Notes:   observes only; it never drives anything back into the block
`timescale 1ns/1ps
module bmt_buzzer_partner (
  input  wire logic sys_clk,
  input  wire logic pin_level,
  input  wire logic power_on,
  output int        now,
  output int        edges,
  output int        half_len,
  output int        last_edge,
  output int        pow_len
);
  int   run;
  logic pin_q;

  initial begin
    now = 0;
    edges = 0;
    half_len = 0;
    last_edge = 0;
    pow_len = 0;
    run = 0;
    pin_q = 1'b0;
  end

  // a piezo only reacts to level changes, so count changes and their spacing
  always @(posedge sys_clk) begin
    now <= now + 1;
    pin_q <= pin_level;
    if (pin_level !== pin_q) begin
      edges <= edges + 1;
      half_len <= now - last_edge;
      last_edge <= now;
    end
    // length of the last stretch that the power switch was closed
    run <= power_on ? run + 1 : 0;
    if (!power_on && run > 0) pow_len <= run;
  end
endmodule // bmt_buzzer_partner

//--- bmt_pkg.sv
// Purpose: constants and types of the buzzer and melody tone generator
// Assumes: 8-bit registers on a 16-bit address, printed byte offsets
// Notes:   one definition per number; the design imports all of it
package bmt_pkg;
  // register offsets
  localparam logic [15:0] ADDR_A_DIV_LO = 16'hA040;
  localparam logic [15:0] ADDR_A_DIV_HI = 16'hA041;
  localparam logic [15:0] ADDR_A_DUR    = 16'hA042;
  localparam logic [15:0] ADDR_A_PAU    = 16'hA043;
  localparam logic [15:0] ADDR_B_DIV_LO = 16'hA044;
  localparam logic [15:0] ADDR_B_DIV_HI = 16'hA045;
  localparam logic [15:0] ADDR_B_DUR    = 16'hA046;
  localparam logic [15:0] ADDR_B_PAU    = 16'hA047;
  localparam logic [15:0] ADDR_CFG      = 16'hA048;
  localparam logic [15:0] ADDR_HOLD     = 16'hA049;
  localparam logic [15:0] ADDR_TU       = 16'hA04A;
  localparam logic [15:0] ADDR_IRQ_STAT = 16'hA04B;
  localparam logic [15:0] ADDR_IRQ_MASK = 16'hA04C;
  // buzzer_config fields
  localparam int CFG_EN  = 7;
  localparam int CFG_INV = 6;
  localparam int CFG_IEB = 5;
  localparam int CFG_IEA = 4;
  localparam int CFG_FB  = 3;
  localparam int CFG_FA  = 2;
  localparam int CFG_GOB = 1;
  localparam int CFG_GOA = 0;
  // time_unit_control fields
  localparam int TU_MSB  = 7;
  localparam int TU_LSB  = 6;
  localparam int TU_BASE = 4;
  localparam int TU_IE   = 1;
  localparam int TU_FLAG = 0;
  // irq status and mask bits
  localparam int IRQ_A = 0;
  localparam int IRQ_B = 1;
  localparam int IRQ_H = 2;
  // reset value of every register
  localparam logic [7:0] REG_RESET = 8'h00;
  // timing
  localparam int SLOW_CLK_HZ = 32000;
  localparam int UNIT_MS     = 1;
  localparam int SLOW_EDGES_PER_UNIT = SLOW_CLK_HZ * UNIT_MS / 1000;
  localparam int BASE_DIV_LO = 32;
  localparam int BASE_DIV_HI = 64;
  // register bus request
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } bmt_bus_req_type;
  // sequencer states
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_TONE  = 3'b010,
    ST_PAUSE = 3'b100
  } bmt_state_type;
endpackage

//--- tb_bmt_buzzer_melody.sv
// Purpose: self-checking bench for the buzzer and melody tone generator
// Assumes: one slow edge per unit, so a 1 ms unit is one slow period
// Notes:   all register traffic goes through the rd and wr tasks
`timescale 1ns/1ps
module tb_bmt_buzzer_melody;
  import bmt_pkg::*;
  localparam int U0 = 312; // sys cycles in one slow period
  logic            sys_clk;
  logic            rst_b;
  logic            slow_clk;
  bmt_bus_req_type req;
  logic [7:0]      rd_data;
  logic            pin;
  logic            hold_on;
  logic            irq;
  logic [7:0]      d;
  int              bad_count;
  int              compares;
  int              now, edges, half_len, last_edge, pow_len, i, e0;
  logic [15:0] ra [12] = '{ADDR_A_DIV_LO, ADDR_A_DIV_HI, ADDR_A_DUR, ADDR_A_PAU,
    ADDR_B_DIV_LO, ADDR_B_DIV_HI, ADDR_B_DUR, ADDR_B_PAU, ADDR_HOLD, ADDR_TU,
    ADDR_IRQ_MASK, 16'hA050};
  logic [7:0] wv [12] = '{8'h5A, 8'hFF, 8'hA5, 8'h3C, 8'hC3, 8'hF7, 8'h96, 8'h69,
    8'h81, 8'hD3, 8'h07, 8'h55};
  logic [7:0] ev [12] = '{8'h5A, 8'h0F, 8'hA5, 8'h3C, 8'hC3, 8'h07, 8'h96, 8'h69,
    8'h81, 8'hD2, 8'h07, 8'h00};

  bmt_buzzer_melody #(.EDGES_PER_UNIT(1)) dut (
    .sys_clk(sys_clk), .rst_b(rst_b), .bus_req(req), .rd_data(rd_data),
    .slow_32k_clock(slow_clk), .buzzer_output_pin(pin),
    .supply_hold_active(hold_on), .irq(irq));

  bmt_buzzer_partner buzzer (
    .sys_clk(sys_clk), .pin_level(pin), .power_on(hold_on), .now(now),
    .edges(edges), .half_len(half_len), .last_edge(last_edge), .pow_len(pow_len));

  // the slow clock has its own odd phase against sys_clk on purpose
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  initial begin
    slow_clk = 1'b0;
    #7;
    forever #15625 slow_clk = ~slow_clk;
  end

  task automatic test_done;
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
    compares++;
    if (s !== e) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic chk_rng(input string n, input int lo, input int hi, input int s);
    compares++;
    if (s < lo || s > hi) begin
      bad_count++;
      $display("CHECK FAILED %s expected %0d..%0d seen %0d", n, lo, hi, s);
    end
  endtask

  // a wait that runs out of its bound ends the run as a failure
  task automatic give_up(input string n);
    bad_count++;
    $display("CHECK FAILED %s expected done seen timeout", n);
    test_done();
  endtask

  task automatic do_reset;
    @(posedge sys_clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_b <= 1'b1;
  endtask

  // strobes are one cycle and every task waits an edge before driving again
  task automatic wr(input logic [15:0] a, input logic [7:0] v);
    @(posedge sys_clk);
    req <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: v};
    @(posedge sys_clk);
    req.wr <= 1'b0;
  endtask

  task automatic rd(input logic [15:0] a, output logic [7:0] v);
    @(posedge sys_clk);
    req <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
    @(posedge sys_clk);
    req.rd <= 1'b0;
    #1 v = rd_data;
  endtask

  task automatic rc(input logic [15:0] a, input logic [7:0] e, input string n);
    rd(a, d);
    chk(n, e, d);
  endtask

  // poll a playing bit; a stuck bit ends the run
  task automatic wait_cfg(input int b, input logic v);
    for (i = 0; i < 10000; i++) begin
      rd(ADDR_CFG, d);
      if (d[b] === v) break;
    end
    if (i == 10000) begin
      bad_count++;
      $display("CHECK FAILED playing bit expected %b seen %b", v, d[b]);
      test_done();
    end
  endtask

  task automatic tone(input logic [7:0] tu, input logic [7:0] cfg, input int half);
    wr(ADDR_TU, tu);
    wr(ADDR_CFG, cfg);
    e0 = edges;
    for (i = 0; i < 30000 && edges < e0 + 3; i++) @(posedge sys_clk);
    if (i == 30000) give_up("tone edges");
    chk_rng("tone half period", half, half, half_len);
    wait_cfg(cfg[1] ? CFG_GOB : CFG_GOA, 1'b0);
  endtask

  // note A of two units tone and one unit pause in the given unit
  task automatic timing(input logic [1:0] tu);
    int u;
    int t0;
    u = U0 << tu;
    wr(ADDR_TU, {tu, 6'h00});
    t0 = now;
    wr(ADDR_CFG, 8'h81);
    wait_cfg(CFG_GOA, 1'b1);
    wait_cfg(CFG_GOA, 1'b0);
    // the last pin change may lead the tone's end by one half period (64 cycles)
    chk_rng("tone length", u - 64, 3 * u, last_edge - t0);
    chk_rng("note length", 2 * u, 4 * u, now - t0);
  endtask

  initial begin
    repeat (100000) @(posedge sys_clk);
    bad_count++;
    $display("CHECK FAILED run length expected end seen timeout");
    test_done();
  end

  initial begin
    rst_b = 1'b0;
    req = '0;
    bad_count = 0;
    compares = 0;
    do_reset();
    // reset values, then read back what each register keeps
    for (int k = 0; k < 12; k++) rc(ra[k], 8'h00, "reset value");
    rc(ADDR_CFG, 8'h00, "config reset");
    for (int k = 0; k < 12; k++) wr(ra[k], wv[k]);
    for (int k = 0; k < 12; k++) rc(ra[k], ev[k], "readback");
    do_reset();
    // tone pitch for both bases and a divisor using the high byte
    wr(ADDR_A_DIV_LO, 8'h03);
    wr(ADDR_A_DUR, 8'h08);
    tone(8'h00, 8'h81, 64);
    tone(8'h10, 8'h81, 128);
    wr(ADDR_B_DIV_LO, 8'h01);
    wr(ADDR_B_DIV_HI, 8'hF1);
    wr(ADDR_B_DUR, 8'h30);
    tone(8'h00, 8'h82, 4128);
    // durations and pauses in every unit
    wr(ADDR_A_DUR, 8'h02);
    wr(ADDR_A_PAU, 8'h01);
    for (int k = 0; k < 4; k++) timing(k[1:0]);
    // supply-hold window
    wr(ADDR_HOLD, 8'h03);
    wr(ADDR_TU, 8'h02);
    wr(ADDR_CFG, 8'h81);
    for (i = 0; i < 5000; i++) begin
      @(posedge sys_clk);
      #1;
      if (hold_on === 1'b0) break;
    end
    if (i == 5000) give_up("hold window");
    // the partner latches the length one edge after the switch opens
    @(posedge sys_clk);
    #1;
    chk_rng("hold window", 2 * U0, 4 * U0, pow_len);
    rc(ADDR_TU, 8'h03, "hold flag");
    rc(ADDR_IRQ_STAT, 8'h04, "hold status");
    wr(ADDR_TU, 8'h00);
    rc(ADDR_TU, 8'h00, "hold flag clear");
    wait_cfg(CFG_GOA, 1'b0);
    // note end flag, masking and read-to-clear status
    wr(ADDR_IRQ_MASK, 8'h00);
    wr(ADDR_CFG, 8'h91);
    wait_cfg(CFG_GOA, 1'b1);
    wait_cfg(CFG_GOA, 1'b0);
    rc(ADDR_CFG, 8'h94, "end flag A");
    chk("masked irq", 8'h00, {7'h00, irq});
    wr(ADDR_IRQ_MASK, 8'h01);
    repeat (2) @(posedge sys_clk);
    #1 chk("irq", 8'h01, {7'h00, irq});
    rc(ADDR_IRQ_STAT, 8'h01, "status A");
    repeat (2) @(posedge sys_clk);
    #1 chk("irq cleared", 8'h00, {7'h00, irq});
    wr(ADDR_CFG, 8'h90);
    rc(ADDR_CFG, 8'h90, "flag write zero");
    // both starts together, then a second A while B plays
    wr(ADDR_CFG, 8'hB3);
    wait_cfg(CFG_GOA, 1'b1);
    chk("B idle while A", 8'h00, {7'h00, d[CFG_GOB]});
    wait_cfg(CFG_GOB, 1'b1);
    chk("A idle while B", 8'h00, {7'h00, d[CFG_GOA]});
    wr(ADDR_CFG, 8'hBD);
    wait_cfg(CFG_GOA, 1'b1);
    chk("ping-pong A", 8'h00, {7'h00, d[CFG_GOB]});
    wait_cfg(CFG_GOA, 1'b0);
    rc(ADDR_CFG, 8'hBC, "both flags");
    rc(ADDR_IRQ_STAT, 8'h03, "status A B");
    // polarity when idle and while disabled
    wr(ADDR_CFG, 8'hC0);
    repeat (2) @(posedge sys_clk);
    #1 chk("inverted idle", 8'h01, {7'h00, pin});
    wr(ADDR_CFG, 8'h40);
    repeat (2) @(posedge sys_clk);
    #1 chk("inverted off", 8'h01, {7'h00, pin});
    // disable in mid-note, then a start that must be ignored
    wr(ADDR_A_DUR, 8'h40);
    wr(ADDR_CFG, 8'h81);
    wait_cfg(CFG_GOA, 1'b1);
    wr(ADDR_CFG, 8'h00);
    rc(ADDR_CFG, 8'h00, "stopped");
    e0 = edges;
    repeat (400) @(posedge sys_clk);
    chk_rng("silent edges", e0, e0, edges);
    chk("pin off", 8'h00, {7'h00, pin});
    wr(ADDR_CFG, 8'h80);
    rc(ADDR_CFG, 8'h80, "go zero");
    wr(ADDR_CFG, 8'h01);
    rc(ADDR_CFG, 8'h00, "go disabled");
    test_done();
  end
endmodule // tb_bmt_buzzer_melody
